// ---- rtl/sync_memory_controller_cfg.svh ----
// Purpose: named constants for the synchronous memory controller
// Assumes: 32-bit bus addresses, 14 memory address lines
// Notes: domain is picked by the low two bits of the top address nibble
`ifndef SYNC_MEMORY_CONTROLLER_CFG_SVH
`define SYNC_MEMORY_CONTROLLER_CFG_SVH
`define DOM_MSB 31
`define DOM_LSB 28
`define MODE_MSB 23
`define MODE_LSB 10
`define ROW_MSB 23
`define ROW_LSB 10
`define COL_MSB 9
`define COL_LSB 1
`define GC_INIT 0
`define GC_MODE 1
`define RCD_MIN 2
`define RCD_MAX 3
`define CL_MIN 2
`define CL_MAX 8
`define BL_WIDE 4
`define BL_NARROW 8
`define SEG_64_MASK 4'h3
`define SEG_128_MASK 4'h2
`define SEG_NIB_MSB 27
`define SEG_NIB_LSB 24
`define SEG_64_OFF_MSB 23
`define SEG_64_OFF_LSB 21
`define SEG_128_OFF_MSB 23
`define SEG_128_OFF_LSB 21
`endif

// ---- rtl/sync_memory_controller_pkg.sv ----
// Purpose: shared types for the synchronous memory controller
// Assumes: nothing beyond the constants header
// Notes: command codes follow the usual ras/cas/we order
package sync_memory_controller_pkg;
  typedef enum logic [2:0] {
    CMD_NOP = 3'h7,
    CMD_ACTIVE = 3'h3,
    CMD_READ = 3'h5,
    CMD_WRITE = 3'h4,
    CMD_MODE = 3'h0
  } mem_cmd_e;
  typedef logic [13:0] mem_addr_t;
endpackage

// ---- rtl/sync_memory_controller_latency.sv ----
// Purpose: delay counter for activate-to-access and column latency waits
// Assumes: load and the count value come from the sequencer
// Notes: done pulses after exactly the loaded number of cycles
`include "sync_memory_controller_cfg.svh"
module sync_memory_controller_latency #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  output logic done
);
  typedef struct packed {
    logic [WIDTH-1:0] left;
    logic busy;
  } lat_s;
  lat_s cur, next_cur;

  // write latency plus its two extra edges reaches ten counts
  if (WIDTH < 4) begin : g_width_check
    $error("counter width must be at least four");
  end

  always_comb begin
    next_cur = cur;
    if (load) begin
      next_cur.left = count - WIDTH'(1);
      next_cur.busy = 1'b1;
    end else if (cur.busy) begin
      if (cur.left == '0) begin
        next_cur.busy = 1'b0;
      end else begin
        next_cur.left = cur.left - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign done = cur.busy && (cur.left == '0);
endmodule

// ---- rtl/sync_memory_controller_core.sv ----
// Purpose: synchronous memory controller setup and access sequencing
// Assumes: one access request at a time, held until done
// Notes: refresh and clock-enable gating are handled elsewhere
`include "sync_memory_controller_cfg.svh"
module sync_memory_controller_core
  import sync_memory_controller_pkg::*;
#(
  parameter int DOMAINS = 4,
  parameter int DATA_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // global configuration
  input wire logic [1:0] global_config,
  input wire logic [DOMAINS-1:0] clock_enable_select,
  // per-domain configuration, plus the shared refresh timer
  input wire logic [DOMAINS-1:0][1:0] activate_to_access_delay,
  input wire logic [DOMAINS-1:0][3:0] column_latency,
  input wire logic [DOMAINS-1:0] external_width_select,
  input wire logic [DOMAINS-1:0] auto_precharge,
  input wire logic [DOMAINS-1:0] device_is_128mb,
  input wire logic [15:0] refresh_interval_timer,
  // bus request
  input wire logic req,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  output logic req_done,
  output logic req_error,
  output logic [DATA_W-1:0] rd_data,
  // memory side
  output logic [DOMAINS-1:0] chip_select_n,
  output logic [DOMAINS-1:0] memory_clock_enable,
  output logic [2:0] mem_cmd,
  output sync_memory_controller_pkg::mem_addr_t memory_address_out,
  output logic [3:0] burst_length,
  input wire logic [DATA_W-1:0] mem_dq_in,
  // status
  output logic mode_load_select,
  output logic [15:0] refresh_interval
);
  import sync_memory_controller_pkg::*;

  // elaboration checks: the select decode only serves four domains
  if (DOMAINS != 4) begin : g_dom_check
    $error("domain count must be four");
  end
  if (DATA_W < 1) begin : g_width_check
    $error("data width must be positive");
  end

  // ==========================================
  // helpers
  function automatic logic [3:0] clamp_cl(input logic [3:0] v);
    if (v < 4'(`CL_MIN)) return 4'(`CL_MIN);
    if (v > 4'(`CL_MAX)) return 4'(`CL_MAX);
    return v;
  endfunction

  function automatic logic seg_ok(input logic [31:0] a, input logic big);
    logic [3:0] nib;
    nib = a[`SEG_NIB_MSB:`SEG_NIB_LSB];
    if (big) begin
      return ((nib & `SEG_128_MASK) == 4'h0) && (a[`SEG_128_OFF_MSB:`SEG_128_OFF_LSB] == 3'h0);
    end
    return ((nib & `SEG_64_MASK) == 4'h0) && (a[`SEG_64_OFF_MSB:`SEG_64_OFF_LSB] == 3'h0);
  endfunction

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ACT = 5'h02,
    ST_ACCESS = 5'h04,
    ST_LAT = 5'h08,
    ST_DONE = 5'h10
  } state_e;

  typedef struct packed {
    state_e st;
    logic [1:0] dom;
    logic [2:0] cmd;
    logic [13:0] addr;
    logic [DOMAINS-1:0] cs_n;
    logic write;
    logic mode;
    logic done;
    logic err;
    logic [DATA_W-1:0] data;
  } core_s;
  core_s cur, next_cur;

  logic lat_load;
  logic [3:0] lat_count;
  logic lat_done;
  logic [1:0] dsel;
  logic [3:0] cl_eff;
  logic [1:0] rcd_eff;
  logic mode_on;

  assign dsel = req_addr[`DOM_LSB+1:`DOM_LSB];
  assign mode_on = global_config[`GC_INIT] && global_config[`GC_MODE];
  assign cl_eff = clamp_cl(column_latency[cur.dom]);
  assign rcd_eff = activate_to_access_delay[cur.dom][0] ? 2'(`RCD_MAX) : 2'(`RCD_MIN);

  sync_memory_controller_latency #(.WIDTH(4)) u_lat (
    .clk(clk),
    .resetn(resetn),
    .load(lat_load),
    .count(lat_count),
    .done(lat_done)
  );

  // ==========================================
  // sequencer
  always_comb begin
    next_cur = cur;
    next_cur.cmd = CMD_NOP;
    next_cur.done = 1'b0;
    lat_load = 1'b0;
    lat_count = 4'h0;
    unique case (cur.st)
      ST_IDLE: begin
        next_cur.cs_n = '1;
        // req is still high in the done cycle; taking it would repeat the access
        if (req && !cur.done) begin
          next_cur.dom = dsel;
          next_cur.write = req_write;
          next_cur.err = 1'b0;
          next_cur.cs_n = ~(DOMAINS'(1) << dsel);
          if (mode_on && !req_write) begin
            next_cur.mode = 1'b1;
            next_cur.cmd = CMD_MODE;
            next_cur.addr = req_addr[`MODE_MSB:`MODE_LSB];
            next_cur.st = ST_DONE;
          end else if (!seg_ok(req_addr, device_is_128mb[dsel])) begin
            next_cur.err = 1'b1;
            next_cur.cs_n = '1;
            next_cur.st = ST_DONE;
          end else begin
            next_cur.mode = 1'b0;
            next_cur.cmd = CMD_ACTIVE;
            next_cur.addr = req_addr[`ROW_MSB:`ROW_LSB];
            next_cur.st = ST_ACT;
          end
        end
      end
      ST_ACT: begin
        lat_load = 1'b1;
        lat_count = 4'(rcd_eff) - 4'h1;
        next_cur.st = ST_ACCESS;
      end
      ST_ACCESS: begin
        if (lat_done) begin
          next_cur.cmd = cur.write ? CMD_WRITE : CMD_READ;
          next_cur.addr = {3'h0, auto_precharge[cur.dom], 1'b0, req_addr[`COL_MSB:`COL_LSB]};
          lat_load = 1'b1;
          // one extra count: the device sees the command one edge after it is launched
          lat_count = cur.write ? cl_eff + 4'h2 : cl_eff + 4'h1;
          next_cur.st = ST_LAT;
        end
      end
      ST_LAT: begin
        if (lat_done) begin
          if (!cur.write) begin
            next_cur.data = mem_dq_in;
          end
          next_cur.st = ST_DONE;
        end
      end
      ST_DONE: begin
        next_cur.done = 1'b1;
        next_cur.cs_n = '1;
        next_cur.st = ST_IDLE;
      end
      default: begin
        next_cur.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur <= '{st: ST_IDLE, cmd: CMD_NOP, cs_n: '1, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================
  // outputs
  assign req_done = cur.done;
  assign req_error = cur.done && cur.err;
  assign rd_data = cur.data;
  assign chip_select_n = cur.cs_n;
  assign mem_cmd = cur.cmd;
  assign memory_address_out = cur.addr;
  assign memory_clock_enable = clock_enable_select;
  assign burst_length = external_width_select[cur.dom] ? 4'(`BL_NARROW) : 4'(`BL_WIDE);
  assign mode_load_select = mode_on;
  assign refresh_interval = refresh_interval_timer;

  // ==========================================
  // checks
  sequence act_seq;
    cur.cmd == CMD_ACTIVE;
  endsequence
  sequence acc_seq;
    cur.cmd == CMD_READ || cur.cmd == CMD_WRITE;
  endsequence
  // a request is only taken in idle, and not in the done cycle
  sequence take_seq;
    cur.st == ST_IDLE && req && !cur.done;
  endsequence

  mode_load_a: assert property (@(posedge clk) disable iff (!resetn)
    take_seq ##0 (!req_write && mode_on) |=> cur.cmd == CMD_MODE)
    else $error("mode read did not load mode");
  mode_addr_a: assert property (@(posedge clk) disable iff (!resetn)
    take_seq ##0 (!req_write && mode_on) |=> cur.addr == $past(req_addr[`MODE_MSB:`MODE_LSB]))
    else $error("mode word wrong");
  act_gap_a: assert property (@(posedge clk) disable iff (!resetn)
    act_seq ##1 1'b1 |-> ##[1:3] (cur.cmd == CMD_READ || cur.cmd == CMD_WRITE))
    else $error("access late after activate");
  act_nozero_a: assert property (@(posedge clk) disable iff (!resetn)
    act_seq |=> cur.cmd == CMD_NOP)
    else $error("access too early");
  rcd_min_a: assert property (@(posedge clk) disable iff (!resetn)
    act_seq ##0 (rcd_eff == 2'(`RCD_MIN)) |-> ##2 acc_seq)
    else $error("access not two cycles after activate");
  rcd_max_a: assert property (@(posedge clk) disable iff (!resetn)
    act_seq ##0 (rcd_eff == 2'(`RCD_MAX)) |-> ##3 acc_seq)
    else $error("access not three cycles after activate");
  // capture on the cl_eff-th clock after the read: the second for the shortest latency, the eighth for the longest
  rd_cl_min_a: assert property (@(posedge clk) disable iff (!resetn)
    cur.cmd == CMD_READ && cl_eff == 4'(`CL_MIN) |-> ##3 cur.st == ST_DONE)
    else $error("read capture off for shortest latency");
  rd_cl_max_a: assert property (@(posedge clk) disable iff (!resetn)
    cur.cmd == CMD_READ && cl_eff == 4'(`CL_MAX) |-> ##9 cur.st == ST_DONE)
    else $error("read capture off for longest latency");
  rd_lat_a: assert property (@(posedge clk) disable iff (!resetn)
    cur.cmd == CMD_READ |-> ##[2:9] cur.st == ST_DONE)
    else $error("read latency wrong");
  wr_lat_a: assert property (@(posedge clk) disable iff (!resetn)
    cur.cmd == CMD_WRITE |=> ##2 cur.st == ST_LAT)
    else $error("write latency too short");
  // write one clock longer than read
  wr_cl_min_a: assert property (@(posedge clk) disable iff (!resetn)
    cur.cmd == CMD_WRITE && cl_eff == 4'(`CL_MIN) |-> ##4 cur.st == ST_DONE)
    else $error("write latency not one more than read");
  burst_sel_a: assert property (@(posedge clk) disable iff (!resetn)
    burst_length == (external_width_select[cur.dom] ? 4'h8 : 4'h4))
    else $error("burst length wrong");
  normal_ret_a: assert property (@(posedge clk) disable iff (!resetn)
    take_seq ##0 (!mode_on && seg_ok(req_addr, device_is_128mb[dsel])) |=> cur.cmd == CMD_ACTIVE)
    else $error("normal access not resumed");
  seg_err_a: assert property (@(posedge clk) disable iff (!resetn)
    take_seq ##0 ((!mode_on || req_write) && !seg_ok(req_addr, device_is_128mb[dsel])) |=> cur.cmd == CMD_NOP && cur.cs_n == '1 && cur.err)
    else $error("address outside segments not refused");
  cs_dom_a: assert property (@(posedge clk) disable iff (!resetn)
    act_seq |-> cur.cs_n == ~(DOMAINS'(1) << cur.dom))
    else $error("select does not match domain");
  cs_one_a: assert property (@(posedge clk) disable iff (!resetn)
    $countones(~cur.cs_n) <= 1)
    else $error("more than one select");
endmodule

// ---- sim/sdram_model.sv ----
// Purpose: far-side memory model that answers reads
// Assumes: read data is due column-latency clocks after the read command
// Notes: dq changes every cycle when the device is not driving it
module sdram_model
  import sync_memory_controller_pkg::*;
(
  // clock
  input wire logic clk,
  // command side
  input wire logic [2:0] mem_cmd,
  input wire logic [3:0] chip_select_n,
  input wire logic [3:0] cl,
  input wire logic [15:0] word,
  // data
  output logic [15:0] dq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt = 4'h0;
  logic [15:0] junk = 16'h0;
  always @(posedge clk) begin
    junk <= junk + 16'h1357;
    if (mem_cmd == CMD_READ && chip_select_n != 4'hF) cnt <= 4'h1;
    else if (cnt != 4'h0) cnt <= cnt + 4'h1;
  end
  // an idle bus never repeats the last word, so a late capture cannot pass
  assign dq = (cnt == cl) ? word : ~junk;
endmodule

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the memory controller core
// Assumes: 10 MHz clock, config bits driven as plain ports
// Notes: command gaps are timed by a monitor on mem_cmd
module tb_top;
  import sync_memory_controller_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, resetn = 0, req = 0, req_write = 0;
  logic [1:0] global_config = 2'h0;
  logic [3:0] clock_enable_select = 4'h5, external_width_select = 4'h0;
  logic [3:0] auto_precharge = 4'h0, device_is_128mb = 4'h0, cl;
  logic [3:0][1:0] activate_to_access_delay = '0;
  logic [3:0][3:0] column_latency = '0;
  logic [15:0] refresh_interval_timer = 16'h1234, word = 16'h0;
  logic [31:0] req_addr = 32'h0;
  logic req_done, req_error, mode_load_select;
  logic [15:0] rd_data, mem_dq_in, refresh_interval;
  logic [3:0] chip_select_n, memory_clock_enable, burst_length, cs_seen;
  logic [2:0] mem_cmd;
  mem_addr_t memory_address_out, mode_addr, acc_addr;
  logic err_seen;
  logic [15:0] data_seen;
  int miscompares = 0, checks = 0, cyc = 0, act_t = 0, acc_t = 0, n, nr;
  always #50 clk = ~clk;
  assign cl = column_latency[req_addr[29:28]];
  sync_memory_controller_core sync_memory_controller_core_i (.clk, .resetn, .global_config, .clock_enable_select, .activate_to_access_delay,
    .column_latency, .external_width_select, .auto_precharge, .device_is_128mb, .refresh_interval_timer,
    .req, .req_write, .req_addr, .req_done, .req_error, .rd_data, .chip_select_n, .memory_clock_enable,
    .mem_cmd, .memory_address_out, .burst_length, .mem_dq_in, .mode_load_select, .refresh_interval);
  sdram_model sdram_model_i (.clk, .mem_cmd, .chip_select_n, .cl, .word, .dq(mem_dq_in));
  // ==========
  // monitor and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      complete_run();
    end
    if (mem_cmd == CMD_ACTIVE) act_t <= cyc;
    if (mem_cmd == CMD_READ || mem_cmd == CMD_WRITE) acc_t <= cyc;
    if (mem_cmd == CMD_READ || mem_cmd == CMD_WRITE) acc_addr <= memory_address_out;
    if (mem_cmd == CMD_MODE) mode_addr <= memory_address_out;
    if (mem_cmd != CMD_NOP) cs_seen <= chip_select_n;
  end
  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (exp !== got) begin
      miscompares++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  // one request held until done; n counts cycles to done
  task automatic access(input logic wr, input logic [31:0] a);
    n = 0;
    @(posedge clk);
    req <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    do begin
      @(negedge clk);
      n++;
    end while (req_done !== 1'b1 && n < 60);
    // take what the answer carries while it stands
    err_seen = req_error;
    data_seen = rd_data;
    chk("done", 1, n < 60);
    @(posedge clk);
    req <= 1'b0;
  endtask
  // ==========
  // scenarios
  task automatic t_static();
    chk("cke", 4'h5, memory_clock_enable); // enables follow select
    chk("refresh", 16'h1234, refresh_interval); // timer setting
  endtask
  task automatic t_mode();
    // mode load by read at domain base plus pattern
    global_config <= 2'h3;
    access(0, 32'h1000_0000 | (32'h0232 << 10));
    chk("mode sel", 1, mode_load_select); // both init bits set
    chk("mode addr", 14'h0232, mode_addr); // bits to address lines
    chk("mode cs", 4'hD, cs_seen); // nibble picks domain
    global_config <= 2'h0;
    word <= 16'h6B2D;
    column_latency[1] <= 4'h2;
    access(0, 32'h1000_0000);
    chk("after mode", 16'h6B2D, data_seen); // normal reads resume
    chk("mode sel off", 0, mode_load_select); // init bits cleared
  endtask
  task automatic t_read();
    column_latency[3] <= 4'h8;
    for (int r = 0; r < 4; r++) begin
      for (int c = 2; c <= 8; c++) begin
        activate_to_access_delay[2] <= 2'(r); // delay count chosen by software
        column_latency[2] <= 4'(c);
        external_width_select[2] <= r[0];
        auto_precharge[2] <= (r < 3); // precharge normally on
        word <= 16'(r * 256 + c);
        access(0, 32'h2400_0000);
        chk("rd_data", 16'(r * 256 + c), data_seen); // latency per domain
        chk("ap bit", (r < 3), acc_addr[10]); // precharge flag on address line
        chk("rcd gap", 2 + r % 2, acc_t - act_t); // two or three
        chk("burst", r[0] ? 8 : 4, burst_length); // burst from width
      end
    end
  endtask
  task automatic t_write();
    column_latency[2] <= 4'h2;
    access(0, 32'h2000_0000);
    nr = n;
    access(1, 32'h2000_0000); // single-location write, no write buffer
    chk("write extra", nr + 1, n); // write one clock longer
  endtask
  task automatic t_seg();
    logic [31:0] a[9] = '{32'h0, 32'h0400_0000, 32'h0C1F_FFFE, 32'h0020_0000, 32'h0100_0000,
      32'h0100_0000, 32'h0D00_0000, 32'h0200_0000, 32'h0E00_0000};
    logic e[9] = '{0, 0, 0, 1, 1, 0, 0, 1, 1};
    column_latency[0] <= 4'h2;
    for (int i = 0; i < 9; i++) begin
      device_is_128mb[0] <= (i > 4);
      access(0, a[i]);
      chk("seg error", e[i], err_seen); // segment maps
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_static();
    t_mode();
    t_read();
    t_write();
    t_seg();
    complete_run();
  end
endmodule
